// ==== design/pcs_regs_pkg.sv ====
// Constants for the coding-layer control and status register bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package pcs_regs_pkg;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [15:0] CTRL_IDX       = 16'h3000;
    localparam logic [15:0] STAT_IDX       = 16'h3001;
    localparam logic [15:0] IRQ_STAT_IDX   = 16'h3002;
    localparam logic [15:0] IRQ_MASK_IDX   = 16'h3003;
    localparam int          ADDR_W         = 18;
    localparam logic [17:0] CTRL_ADDR      = {CTRL_IDX, 2'b00};
    localparam logic [17:0] STAT_ADDR      = {STAT_IDX, 2'b00};
    localparam logic [17:0] IRQ_STAT_ADDR  = {IRQ_STAT_IDX, 2'b00};
    localparam logic [17:0] IRQ_MASK_ADDR  = {IRQ_MASK_IDX, 2'b00};
    // Control fields
    localparam int          CTRL_RST_BIT   = 15;
    localparam int          CTRL_LOOP_BIT  = 14;
    localparam int          CTRL_RXSTP_BIT = 10;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic        RXSTP_RESET    = 1'b1;
    // Status fields
    localparam int          STAT_TXLH_BIT  = 11;
    localparam int          STAT_RXLH_BIT  = 10;
    localparam int          STAT_TXLV_BIT  = 9;
    localparam int          STAT_RXLV_BIT  = 8;
    localparam int          STAT_TXSTP_BIT = 6;
    localparam logic [15:0] STAT_RESET     = 16'h0000;
    // Interrupt fields: bit 0 transmit idle seen, bit 1 receive idle seen
    localparam int          IRQ_W          = 2;
    localparam logic [1:0]  IRQ_RESET      = 2'h0;
endpackage

// ==== design/pcs_lpi_control_status_regs.sv ====
// Coding-layer control and status registers with idle-event interrupt.
// Assumes APB master on pclk; idle indications arrive asynchronously.
`timescale 1ns/1ns
module pcs_lpi_control_status_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        transmit_idle_live,
    input  wire logic        receive_idle_live,
    input  wire logic        tx_clock_stoppable,
    output logic             coding_layer_soft_reset,
    output logic             coding_layer_loop_enable,
    output logic             rx_clock_stoppable,
    output logic             irq
);
    // Two-stage synchronisers for the three asynchronous inputs
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] nxt_sync1;
    logic [2:0] nxt_sync2;

    logic        loop_ff;
    logic        rxstp_ff;
    logic        srst_ff;
    logic        txlh_ff;
    logic        rxlh_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic        irq_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    logic        nxt_loop;
    logic        nxt_rxstp;
    logic        nxt_srst;
    logic        nxt_txlh;
    logic        nxt_rxlh;
    logic [1:0]  nxt_irq_stat;
    logic [1:0]  nxt_irq_mask;
    logic        nxt_irq;
    logic [31:0] nxt_prdata;
    logic        nxt_pready;
    logic        nxt_pslverr;

    logic        tx_live;
    logic        rx_live;
    logic        tx_stp;
    logic        access;
    logic        wr;
    logic        rd;
    logic        hit;
    logic        done;
    logic        ctrl_wr;
    logic        soft_rst;
    logic        stat_rd;
    logic        istat_wr;
    logic        imask_wr;
    logic [1:0]  idle_rise;
    logic        lo_lanes;
    logic [15:0] ctrl_view;
    logic [15:0] stat_view;

    assign tx_live = sync2_ff[0];
    assign rx_live = sync2_ff[1];
    assign tx_stp  = sync2_ff[2];

    // One wait state: pready rises in the second access cycle
    assign access   = psel && penable && !pready_ff;
    // Writes land on the edge that sees pready high, as the master expects
    assign done     = psel && penable && pready_ff;
    assign wr       = done && pwrite;
    assign rd       = access && !pwrite;
    assign lo_lanes = &pstrb[1:0];
    assign ctrl_wr  = wr && lo_lanes && (paddr == pcs_regs_pkg::CTRL_ADDR);
    assign soft_rst = ctrl_wr && pwdata[pcs_regs_pkg::CTRL_RST_BIT];
    assign stat_rd  = rd && (paddr == pcs_regs_pkg::STAT_ADDR);
    assign istat_wr = wr && pstrb[0] && (paddr == pcs_regs_pkg::IRQ_STAT_ADDR);
    assign imask_wr = wr && pstrb[0] && (paddr == pcs_regs_pkg::IRQ_MASK_ADDR);
    assign idle_rise = {rx_live & !rxlh_ff, tx_live & !txlh_ff};
    assign hit      = (paddr == pcs_regs_pkg::CTRL_ADDR)
                   || (paddr == pcs_regs_pkg::STAT_ADDR)
                   || (paddr == pcs_regs_pkg::IRQ_STAT_ADDR)
                   || (paddr == pcs_regs_pkg::IRQ_MASK_ADDR);

    always_comb begin
        ctrl_view = pcs_regs_pkg::CTRL_RESET;
        ctrl_view[pcs_regs_pkg::CTRL_LOOP_BIT]  = loop_ff;
        ctrl_view[pcs_regs_pkg::CTRL_RXSTP_BIT] = rxstp_ff;
        stat_view = pcs_regs_pkg::STAT_RESET;
        stat_view[pcs_regs_pkg::STAT_TXLH_BIT]  = txlh_ff;
        stat_view[pcs_regs_pkg::STAT_RXLH_BIT]  = rxlh_ff;
        stat_view[pcs_regs_pkg::STAT_TXLV_BIT]  = tx_live;
        stat_view[pcs_regs_pkg::STAT_RXLV_BIT]  = rx_live;
        stat_view[pcs_regs_pkg::STAT_TXSTP_BIT] = tx_stp;
    end

    always_comb begin
        nxt_sync1 = {tx_clock_stoppable, receive_idle_live, transmit_idle_live};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // Control group: loop enable, receive-clock-halt permission, soft reset pulse
    always_comb begin
        nxt_loop  = loop_ff;
        nxt_rxstp = rxstp_ff;
        nxt_srst  = 1'b0;
        if (ctrl_wr) begin
            nxt_loop  = pwdata[pcs_regs_pkg::CTRL_LOOP_BIT];
            nxt_rxstp = pwdata[pcs_regs_pkg::CTRL_RXSTP_BIT];
            if (soft_rst) begin
                // Soft reset restores control defaults; the written loop value is dropped
                nxt_srst  = 1'b1;
                nxt_loop  = 1'b0;
                nxt_rxstp = pcs_regs_pkg::RXSTP_RESET;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_ff  <= 1'b0;
            rxstp_ff <= pcs_regs_pkg::RXSTP_RESET;
            srst_ff  <= 1'b0;
        end else begin
            loop_ff  <= nxt_loop;
            rxstp_ff <= nxt_rxstp;
            srst_ff  <= nxt_srst;
        end
    end

    // Latch group: idle-seen flags
    always_comb begin
        nxt_txlh = txlh_ff | tx_live;
        nxt_rxlh = rxlh_ff | rx_live;
        // Read clears latches, but a live condition sets them again
        if (stat_rd) begin
            nxt_txlh = tx_live;
            nxt_rxlh = rx_live;
        end
        // Soft reset wins; a still-live idle sets the flag again a cycle later
        if (soft_rst) begin
            nxt_txlh = 1'b0;
            nxt_rxlh = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txlh_ff <= 1'b0;
            rxlh_ff <= 1'b0;
        end else begin
            txlh_ff <= nxt_txlh;
            rxlh_ff <= nxt_rxlh;
        end
    end

    // Interrupt group: sticky status, mask and level output
    always_comb begin
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff | idle_rise;
        // Write-one-to-clear; a new event in the same cycle wins
        if (istat_wr) begin
            nxt_irq_stat = (irq_stat_ff & ~pwdata[1:0]) | idle_rise;
        end
        if (imask_wr) begin
            nxt_irq_mask = pwdata[1:0];
        end
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= pcs_regs_pkg::IRQ_RESET;
            irq_mask_ff <= pcs_regs_pkg::IRQ_RESET;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff      <= nxt_irq;
        end
    end

    // Response group: one wait state, read data and error stand with pready
    always_comb begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pready  = access;
        nxt_pslverr = access && !hit;
        if (rd && hit) begin
            case (paddr)
                pcs_regs_pkg::CTRL_ADDR:     nxt_prdata = {16'h0000, ctrl_view};
                pcs_regs_pkg::STAT_ADDR:     nxt_prdata = {16'h0000, stat_view};
                pcs_regs_pkg::IRQ_STAT_ADDR: nxt_prdata = {30'h0, irq_stat_ff};
                default:                     nxt_prdata = {30'h0, irq_mask_ff};
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata                   = prdata_ff;
    assign pready                   = pready_ff;
    assign pslverr                  = pslverr_ff;
    assign coding_layer_soft_reset  = srst_ff;
    assign coding_layer_loop_enable = loop_ff;
    assign rx_clock_stoppable       = rxstp_ff;
    assign irq                      = irq_ff;
endmodule // pcs_lpi_control_status_regs

// ==== test/pcs_regs_checker_properties.sv ====
// Port-level checks for the coding-layer control and status bank.
// Assumes an APB master that keeps psel and paddr steady through pready.
`timescale 1ns/1ns
module pcs_regs_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        transmit_idle_live,
    input wire logic        receive_idle_live,
    input wire logic        tx_clock_stoppable,
    input wire logic        coding_layer_soft_reset,
    input wire logic        coding_layer_loop_enable,
    input wire logic        rx_clock_stoppable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done = pready && psel && !pwrite;
    wire ctrl_rd = rd_done && paddr == pcs_regs_pkg::CTRL_ADDR;
    wire stat_rd = rd_done && paddr == pcs_regs_pkg::STAT_ADDR;
    // Six cycles covers the two-flop sync plus the read register
    sequence tx_held; transmit_idle_live[*6]; endsequence
    sequence rx_quiet; !receive_idle_live[*6]; endsequence
    sequence stop_held; tx_clock_stoppable[*6]; endsequence
    soft_pulse_a: assert property (coding_layer_soft_reset |=> !coding_layer_soft_reset)
        else $error("soft reset pulse wider than one cycle");
    loop_clear_a: assert property (coding_layer_soft_reset |=> !coding_layer_loop_enable)
        else $error("loop enable survived soft reset");
    rx_stop_set_a: assert property (coding_layer_soft_reset |=> rx_clock_stoppable)
        else $error("receive clock halt permission not restored");
    ctrl_read_a: assert property (ctrl_rd |-> prdata == {17'h0, coding_layer_loop_enable,
        3'h0, rx_clock_stoppable, 10'h0})
        else $error("control readback mismatch");
    stat_rsvd_a: assert property (stat_rd |-> (prdata & 32'hFFFF_F0BF) == 32'h0)
        else $error("status reserved bits set");
    tx_live_a: assert property (tx_held ##0 stat_rd |-> prdata[9] && prdata[11])
        else $error("transmit idle not reported");
    rx_quiet_a: assert property (rx_quiet ##0 stat_rd |-> !prdata[8])
        else $error("receive idle live bit stuck");
    tx_stop_a: assert property (stop_held ##0 stat_rd |-> prdata[6])
        else $error("transmit clock stop permission not reported");
    unmapped_a: assert property (pready && paddr == 18'h0 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule // pcs_regs_checker

bind pcs_lpi_control_status_regs pcs_regs_checker pcs_regs_checker_i (.pclk, .presetn, .psel,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .transmit_idle_live, .receive_idle_live,
    .tx_clock_stoppable, .coding_layer_soft_reset, .coding_layer_loop_enable,
    .rx_clock_stoppable);

// ==== test/pcs_lpi_control_status_regs_tb.sv ====
// Self-checking bench for the coding-layer register bank over APB.
// Assumes one wait state per transfer; pstrb held at all lanes.
`timescale 1ns/1ns
module pcs_lpi_control_status_regs_tb;
    localparam logic [17:0] CA = pcs_regs_pkg::CTRL_ADDR;
    localparam logic [17:0] SA = pcs_regs_pkg::STAT_ADDR;
    typedef struct {logic w; logic [17:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_s;
    row_s        rows [5] = '{'{1'b0, CA, 32'h0, 32'h0000_0400, 1'b0},
                              '{1'b1, CA, 32'h0000_4000, 32'h0, 1'b0},
                              '{1'b0, CA, 32'h0, 32'h0000_4000, 1'b0},
                              '{1'b0, SA, 32'h0, 32'h0, 1'b0},
                              '{1'b0, 18'h0, 32'h0, 32'h0, 1'b1}};
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, er, irq;
    logic        transmit_idle_live, receive_idle_live, tx_clock_stoppable;
    logic        coding_layer_soft_reset, coding_layer_loop_enable, rx_clock_stoppable;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    int          err_total = 0;
    int          comparisons = 0;

    pcs_lpi_control_status_regs pcs_lpi_control_status_regs_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .transmit_idle_live,
        .receive_idle_live, .tx_clock_stoppable, .coding_layer_soft_reset,
        .coding_layer_loop_enable, .rx_clock_stoppable, .irq);

    always #2 pclk = ~pclk;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    // Waits on pready; a hung slave counts as a mismatch
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(32'(pready), 32'h1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task automatic idle(input logic v);
        {transmit_idle_live, receive_idle_live, tx_clock_stoppable} <= {3{v}};
        repeat (8) @(posedge pclk);
    endtask

    task finish_test;
        $display("comparisons %0d, err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = {5'h0, 18'h0, 32'h0, 4'hF};
        {transmit_idle_live, receive_idle_live, tx_clock_stoppable} = 3'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].e);
            chk(32'(er), 32'(rows[i].er));
        end
        chk(32'({coding_layer_loop_enable, rx_clock_stoppable}), 32'h2);
        apb(1'b1, CA, 32'h0000_C000);
        @(posedge pclk);
        chk(32'(coding_layer_soft_reset), 32'h1);
        chk(32'({coding_layer_loop_enable, rx_clock_stoppable}), 32'h1);
        apb(1'b0, CA, 32'h0);
        chk(rd, 32'h0000_0400);
        idle(1'b1);
        apb(1'b0, SA, 32'h0);
        chk(rd, 32'h0000_0F40);
        idle(1'b0);
        apb(1'b0, SA, 32'h0);
        chk(rd, 32'h0000_0C00);
        apb(1'b0, SA, 32'h0);
        chk(rd, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b1, pcs_regs_pkg::IRQ_MASK_ADDR, 32'h3);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b1, pcs_regs_pkg::IRQ_STAT_ADDR, 32'h3);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        idle(1'b1);
        idle(1'b0);
        apb(1'b1, CA, 32'h0000_8000);
        apb(1'b0, SA, 32'h0);
        chk(rd, 32'h0);
        finish_test;
    end

    initial begin
        #12000;
        err_total++;
        finish_test;
    end
endmodule // pcs_lpi_control_status_regs_tb
